// File: include/dsc_defines.svh
// register map, field positions, reset values and timing counts
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

`define DSC_ADDR_CFG      5'h00
`define DSC_ADDR_OFS_I    5'h08
`define DSC_ADDR_OFS_Q    5'h0c

`define DSC_CFG_BIDIR     7
`define DSC_CFG_LSB_FIRST 6
`define DSC_CFG_SOFT_RST  5
`define DSC_CFG_RESET     8'h00
`define DSC_OFS_STEER     7
`define DSC_OFS_RESET     8'h00

`define DSC_RECOVER_MASK  8'h3c
`define DSC_RECOVER_VAL   8'h24

`define DSC_INS_READ      7
`define DSC_INS_CNT_HI    6
`define DSC_INS_CNT_LO    5
`define DSC_INS_ADDR_HI   4

`define DSC_SETTLE_CYC    200

`define DSC_CODE_W        14
`define DSC_MAJOR_N       31
`define DSC_MID_N         15
`define DSC_LSB_W         5

`endif

// File: include/dsc_pkg.sv
// types shared by the serial configuration block
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_INSTR,
    DSC_DATA,
    DSC_DONE
  } dsc_link_state_t;
endpackage

// File: src/dsc_segment_decoder.sv
// segmented 5-4-5 decoder of one converter code into switch controls
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_segment_decoder #(
  parameter int CODE_W = `DSC_CODE_W
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // converter code
  input  wire logic [CODE_W-1:0]      code,
  // switch controls, 1 steers to the positive output
  output logic [`DSC_MAJOR_N-1:0]     majorSwitch,
  output logic [`DSC_MID_N-1:0]       midSwitch,
  output logic [`DSC_LSB_W-1:0]       lsbSwitch
);

  generate
    if (CODE_W != `DSC_CODE_W) begin : g_bad_width
      $error("dsc_segment_decoder: only a 14-bit code is supported");
    end
  endgenerate

  logic [`DSC_MAJOR_N-1:0] next_majorSwitch;
  logic [`DSC_MID_N-1:0]   next_midSwitch;
  logic [`DSC_LSB_W-1:0]   next_lsbSwitch;

  genvar i;
  generate
    for (i = 0; i < `DSC_MAJOR_N; i++) begin : g_major
      assign next_majorSwitch[i] = (code[13:9] > 5'(i));
    end
    for (i = 0; i < `DSC_MID_N; i++) begin : g_mid
      assign next_midSwitch[i] = (code[8:5] > 4'(i));
    end
  endgenerate

  assign next_lsbSwitch = code[4:0];

  // whole code lands on one edge so no mixed segments show
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      majorSwitch <= '0;
      midSwitch   <= '0;
      lsbSwitch   <= '0;
    end else begin
      majorSwitch <= next_majorSwitch;
      midSwitch   <= next_midSwitch;
      lsbSwitch   <= next_lsbSwitch;
    end
  end

  a_major_count: assert property (@(posedge clk) disable iff (rst)
    ##1 ($countones(majorSwitch) == int'($past(code[13:9]))))
    else $error("major thermometer count wrong");

  a_mid_count: assert property (@(posedge clk) disable iff (rst)
    ##1 ($countones(midSwitch) == int'($past(code[8:5]))))
    else $error("middle thermometer count wrong");

  a_lsb_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 (lsbSwitch == $past(code[4:0])
         && majorSwitch[0] == ($past(code[13:9]) != 5'h00)))
    else $error("segments not from one code");

endmodule
`default_nettype wire

// File: src/dsc_serial_config.sv
// serial register port, configuration register and code steering
//
// Overview of operation
// - bidirectional-pin and LSB-first controls sit in bits 7 and 6 of register port_config_and_soft_reset.
// - new port configuration applies at the last bit of its byte, even mid-transfer.
// - soft reset bit resets all other registers at once; register port_config_and_soft_reset keeps its bits.
// - pattern XY1001YX to port_config_and_soft_reset restores lost configuration and resets registers.
// - next port_config_and_soft_reset write, reset low, same XY reprograms multiplier; stable within 200.
// - top five code bits drive 31 equal major sources as thermometer.
// - next four code bits drive 15 sixteenth-weight sources as thermometer.
// - low five code bits drive binary weighted sources directly.
// - each source switches to positive or complementary output by code.
// - bit 7 of 0x08 and 0x0C picks the output taking each offset current.
// - single-resistor mode splits one reference equally, halving each channel's scale.
// - instruction: bit 7 read flag, bits 6:5 byte count, bits 4:0 address.
// - address increments LSB-first, decrements MSB-first, wrapping 0x1F and port_config_and_soft_reset.
// - select high then low restarts instruction phase, dropping partial data.
// - bit 7 of port_config_and_soft_reset makes data pin bidirectional; default keeps separate output.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_serial_config #(
  parameter int SETTLE_CYCLES = `DSC_SETTLE_CYC
) (
  // system clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // serial register port
  input  wire logic                   serialClk,
  input  wire logic                   serialSelectN,
  input  wire logic                   serialDataIoIn,
  output logic                        serialDataIoOut,
  output logic                        serialDataIoOe,
  output logic                        serialDataOut,
  output logic                        serialDataOutOe,
  // converter codes and reference mode pin
  input  wire logic [`DSC_CODE_W-1:0] inPhaseCode,
  input  wire logic [`DSC_CODE_W-1:0] quadratureCode,
  input  wire logic                   singleResistorMode,
  // in-phase converter switches
  output logic [`DSC_MAJOR_N-1:0]     inPhaseMajor,
  output logic [`DSC_MID_N-1:0]       inPhaseMid,
  output logic [`DSC_LSB_W-1:0]       inPhaseLsb,
  // quadrature converter switches
  output logic [`DSC_MAJOR_N-1:0]     quadratureMajor,
  output logic [`DSC_MID_N-1:0]       quadratureMid,
  output logic [`DSC_LSB_W-1:0]       quadratureLsb,
  // offset steering and reference scale
  output logic [6:0]                  inPhaseOffsetCode,
  output logic                        inPhaseOffsetToComp,
  output logic [6:0]                  quadratureOffsetCode,
  output logic                        quadratureOffsetToComp,
  output logic                        referenceHalfScale,
  // clock multiplier
  output logic                        multiplierReprogram,
  output logic                        clockStable
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  generate
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("dsc_serial_config: SETTLE_CYCLES must be at least 1");
    end
  endgenerate

  // ---------------- link domain ----------------
  // select high clears the port asynchronously, the link clock may be stopped
  logic linkRst;
  assign linkRst = rst | serialSelectN;

  dsc_pkg::dsc_link_state_t state;
  dsc_pkg::dsc_link_state_t next_state;
  logic [2:0] bitCnt;
  logic [2:0] next_bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic       isRead;
  logic       next_isRead;
  logic [1:0] remain;
  logic [1:0] next_remain;
  logic [4:0] addr;
  logic [4:0] next_addr;
  logic [7:0] rdByte;
  logic [7:0] next_rdByte;
  logic [7:0] assembled;
  logic       byteDone;
  logic       newLsb;
  logic       wrEn;
  logic [7:0] wrData;

  logic [7:0] reg0;
  logic [7:0] next_reg0;
  logic [7:0] regI;
  logic [7:0] next_regI;
  logic [7:0] regQ;
  logic [7:0] next_regQ;
  logic       armed;
  logic       next_armed;
  logic       wrTog;
  logic       next_wrTog;
  logic       rpTog;
  logic       next_rpTog;
  logic       lsbFirst;
  logic       bidir;

  assign lsbFirst = reg0[`DSC_CFG_LSB_FIRST];
  assign bidir    = reg0[`DSC_CFG_BIDIR];

  function automatic logic [4:0] stepAddr(input logic [4:0] a, input logic up);
    stepAddr = up ? a + 5'h01 : a - 5'h01;
  endfunction

  function automatic logic isRecover(input logic [7:0] d);
    isRecover = ((d & `DSC_RECOVER_MASK) == `DSC_RECOVER_VAL)
                && (d[1] == d[6]) && (d[0] == d[7]);
  endfunction

  function automatic logic [7:0] regRead(input logic [4:0] a, input logic [7:0] r0,
                                         input logic [7:0] ri, input logic [7:0] rq);
    case (a)
      `DSC_ADDR_CFG:   regRead = r0;
      `DSC_ADDR_OFS_I: regRead = ri;
      `DSC_ADDR_OFS_Q: regRead = rq;
      default:         regRead = 8'h00;
    endcase
  endfunction

  // bit order follows the live configuration, so a change lands mid-transfer
  assign assembled = lsbFirst ? {serialDataIoIn, shiftReg[7:1]}
                              : {shiftReg[6:0], serialDataIoIn};
  assign byteDone  = (bitCnt == 3'h7);

  always_comb begin
    next_state    = state;
    next_bitCnt   = bitCnt + 3'h1;
    next_shiftReg = assembled;
    next_isRead   = isRead;
    next_remain   = remain;
    next_addr     = addr;
    next_rdByte   = rdByte;
    newLsb        = lsbFirst;
    wrEn          = 1'b0;
    wrData        = assembled;
    unique case (state)
      dsc_pkg::DSC_INSTR: begin
        if (byteDone) begin
          next_isRead = assembled[`DSC_INS_READ];
          next_remain = assembled[`DSC_INS_CNT_HI:`DSC_INS_CNT_LO];
          next_addr   = assembled[`DSC_INS_ADDR_HI:0];
          next_rdByte = regRead(assembled[`DSC_INS_ADDR_HI:0], reg0, regI, regQ);
          next_state  = dsc_pkg::DSC_DATA;
        end
      end
      dsc_pkg::DSC_DATA: begin
        if (byteDone) begin
          wrEn = !isRead;
          if (!isRead && addr == `DSC_ADDR_CFG) begin
            newLsb = assembled[`DSC_CFG_LSB_FIRST];
          end
          next_addr   = stepAddr(addr, newLsb);
          next_rdByte = regRead(stepAddr(addr, newLsb), reg0, regI, regQ);
          if (remain == 2'h0) begin
            next_state = dsc_pkg::DSC_DONE;
          end else begin
            next_remain = remain - 2'h1;
          end
        end
      end
      dsc_pkg::DSC_DONE: begin
        next_bitCnt = 3'h0;
      end
    endcase
  end

  // partial bytes never reach the registers: this group resets on select high
  always_ff @(posedge serialClk or posedge linkRst) begin
    if (linkRst) begin
      state    <= dsc_pkg::DSC_INSTR;
      bitCnt   <= 3'h0;
      shiftReg <= 8'h00;
      isRead   <= 1'b0;
      remain   <= 2'h0;
      addr     <= 5'h00;
      rdByte   <= 8'h00;
    end else begin
      state    <= next_state;
      bitCnt   <= next_bitCnt;
      shiftReg <= next_shiftReg;
      isRead   <= next_isRead;
      remain   <= next_remain;
      addr     <= next_addr;
      rdByte   <= next_rdByte;
    end
  end

  always_comb begin
    next_reg0  = reg0;
    next_regI  = regI;
    next_regQ  = regQ;
    next_armed = armed;
    next_wrTog = wrTog;
    next_rpTog = rpTog;
    if (wrEn) begin
      next_wrTog = ~wrTog;
      case (addr)
        `DSC_ADDR_CFG: begin
          next_reg0 = wrData;
          next_reg0[`DSC_CFG_SOFT_RST] = 1'b0;
          if (wrData[`DSC_CFG_SOFT_RST]) begin
            next_regI = `DSC_OFS_RESET;
            next_regQ = `DSC_OFS_RESET;
          end
          next_armed = isRecover(wrData);
          if (armed && !wrData[`DSC_CFG_SOFT_RST]
              && wrData[1] == wrData[6] && wrData[0] == wrData[7]) begin
            next_rpTog = ~rpTog;
          end
        end
        `DSC_ADDR_OFS_I: next_regI = wrData;
        `DSC_ADDR_OFS_Q: next_regQ = wrData;
        default: ;
      endcase
    end
  end

  // registers survive select high; the device reset clears them all, a soft reset write clears regI and regQ
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      reg0  <= `DSC_CFG_RESET;
      regI  <= `DSC_OFS_RESET;
      regQ  <= `DSC_OFS_RESET;
      armed <= 1'b0;
      wrTog <= 1'b0;
      rpTog <= 1'b0;
    end else begin
      reg0  <= next_reg0;
      regI  <= next_regI;
      regQ  <= next_regQ;
      armed <= next_armed;
      wrTog <= next_wrTog;
      rpTog <= next_rpTog;
    end
  end

  // read data leaves on the falling edge
  logic outBit;
  logic driving;
  logic next_ioOut;
  logic next_ioOe;
  logic next_sdOut;
  logic next_sdOe;

  always_comb begin
    outBit     = lsbFirst ? rdByte[bitCnt] : rdByte[3'h7 - bitCnt];
    driving    = (state == dsc_pkg::DSC_DATA) && isRead;
    next_ioOut = outBit;
    next_ioOe  = driving && bidir;
    next_sdOut = outBit;
    next_sdOe  = driving && !bidir;
  end

  always_ff @(negedge serialClk or posedge linkRst) begin
    if (linkRst) begin
      serialDataIoOut <= 1'b0;
      serialDataIoOe  <= 1'b0;
      serialDataOut   <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else begin
      serialDataIoOut <= next_ioOut;
      serialDataIoOe  <= next_ioOe;
      serialDataOut   <= next_sdOut;
      serialDataOutOe <= next_sdOe;
    end
  end

  // ---------------- system clock domain ----------------
  // register copies are taken on a synchronised write toggle; the sources
  // hold for at least eight link clocks, far longer than the sync delay
  logic [2:0]       wrSync;
  logic [2:0]       rpSync;
  logic [1:0]       resSync;
  logic             wrEdge;
  logic             rpEdge;
  logic [CNT_W-1:0] settleCnt;
  logic [CNT_W-1:0] next_settleCnt;
  logic [6:0]       next_iCode;
  logic             next_iComp;
  logic [6:0]       next_qCode;
  logic             next_qComp;
  logic             next_clockStable;

  assign wrEdge = wrSync[2] ^ wrSync[1];
  assign rpEdge = rpSync[2] ^ rpSync[1];

  always_comb begin
    next_iCode     = inPhaseOffsetCode;
    next_iComp     = inPhaseOffsetToComp;
    next_qCode     = quadratureOffsetCode;
    next_qComp     = quadratureOffsetToComp;
    next_settleCnt = settleCnt;
    if (wrEdge) begin
      next_iCode = regI[6:0];
      next_iComp = regI[`DSC_OFS_STEER];
      next_qCode = regQ[6:0];
      next_qComp = regQ[`DSC_OFS_STEER];
    end
    if (rpEdge) begin
      next_settleCnt = CNT_W'(SETTLE_CYCLES);
    end else if (settleCnt != '0) begin
      next_settleCnt = settleCnt - CNT_W'(1);
    end
    next_clockStable = (next_settleCnt == '0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrSync                 <= 3'h0;
      rpSync                 <= 3'h0;
      resSync                <= 2'h0;
      inPhaseOffsetCode      <= 7'h00;
      inPhaseOffsetToComp    <= 1'b0;
      quadratureOffsetCode   <= 7'h00;
      quadratureOffsetToComp <= 1'b0;
      referenceHalfScale     <= 1'b0;
      multiplierReprogram    <= 1'b0;
      settleCnt              <= '0;
      clockStable            <= 1'b1;
    end else begin
      wrSync                 <= {wrSync[1:0], wrTog};
      rpSync                 <= {rpSync[1:0], rpTog};
      resSync                <= {resSync[0], singleResistorMode};
      inPhaseOffsetCode      <= next_iCode;
      inPhaseOffsetToComp    <= next_iComp;
      quadratureOffsetCode   <= next_qCode;
      quadratureOffsetToComp <= next_qComp;
      referenceHalfScale     <= resSync[1];
      multiplierReprogram    <= rpEdge;
      settleCnt              <= next_settleCnt;
      clockStable            <= next_clockStable;
    end
  end

  dsc_segment_decoder u_in_phase (
    .clk         (clk),
    .rst         (rst),
    .code        (inPhaseCode),
    .majorSwitch (inPhaseMajor),
    .midSwitch   (inPhaseMid),
    .lsbSwitch   (inPhaseLsb)
  );

  dsc_segment_decoder u_quadrature (
    .clk         (clk),
    .rst         (rst),
    .code        (quadratureCode),
    .majorSwitch (quadratureMajor),
    .midSwitch   (quadratureMid),
    .lsbSwitch   (quadratureLsb)
  );

  // ---------------- checks ----------------
  sequence s_instr_byte;
    (state == dsc_pkg::DSC_INSTR) [*8];
  endsequence

  a_instr_phase: assert property (@(posedge serialClk) disable iff (linkRst)
    (state == dsc_pkg::DSC_INSTR && bitCnt == 3'h0)
      |-> s_instr_byte ##1 (state == dsc_pkg::DSC_DATA))
    else $error("instruction phase not eight bits");

  a_cfg_immediate: assert property (@(posedge serialClk) disable iff (rst)
    (wrEn && addr == `DSC_ADDR_CFG)
      |=> (lsbFirst == $past(wrData[6]) && bidir == $past(wrData[7])))
    else $error("configuration not applied at byte end");

  a_soft_reset: assert property (@(posedge serialClk) disable iff (rst)
    (wrEn && addr == `DSC_ADDR_CFG && wrData[`DSC_CFG_SOFT_RST])
      |=> (regI == `DSC_OFS_RESET && regQ == `DSC_OFS_RESET
           && !reg0[`DSC_CFG_SOFT_RST] && reg0[4:0] == $past(wrData[4:0])))
    else $error("soft reset effect wrong");

  a_recover_arm: assert property (@(posedge serialClk) disable iff (rst)
    (wrEn && addr == `DSC_ADDR_CFG && isRecover(wrData))
      |=> (armed && regI == `DSC_OFS_RESET))
    else $error("recovery write not armed");

  a_addr_step: assert property (@(posedge serialClk) disable iff (linkRst)
    (state == dsc_pkg::DSC_DATA && byteDone && remain != 2'h0)
      |=> (addr == (lsbFirst ? $past(addr) + 5'h01 : $past(addr) - 5'h01)))
    else $error("address step wrong");

  a_bidir_pin: assert property (@(posedge serialClk) disable iff (linkRst)
    (serialDataIoOe |-> bidir && !serialDataOutOe)
      and (serialDataOutOe |-> !bidir))
    else $error("read pin choice wrong");

  a_settle_start: assert property (@(posedge clk) disable iff (rst)
    multiplierReprogram |-> (!clockStable && settleCnt == CNT_W'(SETTLE_CYCLES)))
    else $error("settle count not started");

  a_settle_end: assert property (@(posedge clk) disable iff (rst)
    $rose(clockStable) |-> ($past(settleCnt) == CNT_W'(1)))
    else $error("clock stable at wrong time");

  a_ref_scale: assert property (@(posedge clk) disable iff (rst)
    ($rose(singleResistorMode) ##1 singleResistorMode ##1 singleResistorMode)
      |-> ##1 referenceHalfScale)
    else $error("half scale not applied");

endmodule
`default_nettype wire

// File: test/dsc_host.sv
// behavioural host driving the serial register port
`timescale 1ns/1ps
`default_nettype none

module dsc_host (
  // serial link, clock stands still outside frames except for one edge during reset
  output logic      serialClk,
  output logic      serialSelectN,
  output logic      hostData,
  // read data as seen on both pins
  input  wire logic ioData,
  input  wire logic outData
);
  logic lsbFirst;
  logic bidir;

  initial begin
    serialClk = 1'b0;
    serialSelectN = 1'b1;
    hostData = 1'b0;
    lsbFirst = 1'b0;
    bidir = 1'b0;
    // one link edge while reset is held
    #40 serialClk = 1'b1;
    #7.5 serialClk = 1'b0;
  end

  // drive after the fall, sample on the rise
  task automatic shift(input logic [7:0] w, input int nb, input logic rd,
                       output logic [7:0] r);
    int idx;
    r = 8'h00;
    for (int k = 0; k < nb; k++) begin
      idx = lsbFirst ? k : 7 - k;
      // released line toggles so a stale level cannot pass
      hostData = rd ? ~hostData : w[idx];
      #7.5;
      serialClk = 1'b1;
      r[idx] = bidir ? ioData : outData;
      #7.5;
      serialClk = 1'b0;
    end
  endtask

  // one frame; cut > 0 drops the select after that many bits of the last byte
  task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [4:0] addr,
                      input logic [31:0] w, input int cut, output logic [31:0] r);
    logic [7:0] b;
    logic [4:0] a;
    int         nb;
    r = 32'h0;
    a = addr;
    serialSelectN = 1'b0;
    #7.5;
    shift({rd, cnt, addr}, 8, 1'b0, b);
    for (int i = 0; i <= cnt; i++) begin
      nb = (cut > 0 && i == cnt) ? cut : 8;
      shift(w[8*i +: 8], nb, rd, b);
      r[8*i +: 8] = b;
      if (!rd && a == 5'h00 && nb == 8) begin
        lsbFirst = w[8*i+6];
        bidir = w[8*i+7];
      end
      a = lsbFirst ? a + 5'h01 : a - 5'h01;
    end
    #7.5;
    serialSelectN = 1'b1;
    #30;
  endtask
endmodule

`default_nettype wire

// File: test/dsc_serial_config_tb.sv
// self-checking bench of the serial configuration block
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_serial_config_tb;
  localparam int SETTLE = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sClk, sSelN, hostData, ioOut, ioOe, serial_data_out, sdoOe, ioWire, outWire;
  logic [13:0] iCode, qCode;
  logic        resMode, iComp, qComp, halfScale, reprog, stable;
  logic [30:0] iMaj, qMaj;
  logic [14:0] iMid, qMid;
  logic [4:0]  iLsb, qLsb;
  logic [6:0]  iOfs, qOfs;
  logic [31:0] junk;
  logic [7:0]  mdl [32];
  int          miscompares = 0;
  int          checks = 0;
  int          ioSeen, outSeen, pulses, lowCycles;

  always #10 clk = ~clk;
  assign ioWire = ioOe ? ioOut : hostData;
  assign outWire = sdoOe ? serial_data_out : ~serial_data_out;

  dsc_serial_config #(.SETTLE_CYCLES(SETTLE)) uut (
    .clk(clk), .rst(rst), .serialClk(sClk), .serialSelectN(sSelN),
    .serialDataIoIn(ioWire), .serialDataIoOut(ioOut), .serialDataIoOe(ioOe),
    .serialDataOut(serial_data_out), .serialDataOutOe(sdoOe), .inPhaseCode(iCode),
    .quadratureCode(qCode), .singleResistorMode(resMode), .inPhaseMajor(iMaj),
    .inPhaseMid(iMid), .inPhaseLsb(iLsb), .quadratureMajor(qMaj), .quadratureMid(qMid),
    .quadratureLsb(qLsb), .inPhaseOffsetCode(iOfs), .inPhaseOffsetToComp(iComp),
    .quadratureOffsetCode(qOfs), .quadratureOffsetToComp(qComp),
    .referenceHalfScale(halfScale), .multiplierReprogram(reprog), .clockStable(stable)
  );

  dsc_host host (
    .serialClk(sClk), .serialSelectN(sSelN), .hostData(hostData),
    .ioData(ioWire), .outData(outWire)
  );

  always @(posedge sClk) begin
    if (ioOe === 1'b1) ioSeen++;
    if (sdoOe === 1'b1) outSeen++;
  end

  always @(posedge clk) begin
    if (!rst && reprog === 1'b1) pulses++;
    if (!rst && stable !== 1'b1) lowCycles++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] mrd(input logic [4:0] a);
    return (a == `DSC_ADDR_CFG || a == `DSC_ADDR_OFS_I || a == `DSC_ADDR_OFS_Q) ? mdl[a] : 8'h00;
  endfunction

  task automatic mwr(input logic [4:0] a, input logic [7:0] v);
    if (a == `DSC_ADDR_CFG) begin
      mdl[0] = v & 8'hdf;
      if (v[5]) begin
        mdl[8] = 8'h00;
        mdl[12] = 8'h00;
      end
    end else if (a == `DSC_ADDR_OFS_I || a == `DSC_ADDR_OFS_Q) begin
      mdl[a] = v;
    end
  endtask

  // model steps the address with its own view of the bit order
  task automatic xfer(input logic rd, input int n, input logic [4:0] addr, input logic [31:0] w);
    logic [31:0] r;
    logic [4:0]  a;
    host.xfer(rd, 2'(n - 1), addr, w, 0, r);
    a = addr;
    for (int i = 0; i < n; i++) begin
      if (rd) check("read byte", 32'(r[8*i +: 8]), 32'(mrd(a)));
      else mwr(a, w[8*i +: 8]);
      a = mdl[0][6] ? a + 5'h01 : a - 5'h01;
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic ofs();
    check("i offset", 32'({iComp, iOfs}), 32'(mdl[8]));
    check("q offset", 32'({qComp, qOfs}), 32'(mdl[12]));
  endtask

  function automatic logic [31:0] therm(input logic [4:0] v, input int n);
    logic [31:0] t;
    t = 32'h0;
    for (int i = 0; i < n; i++) t[i] = (v > i);
    return t;
  endfunction

  task automatic codes(input int n);
    logic [13:0] pi, pq;
    for (int c = 0; c < n; c++) begin
      pi = iCode;
      pq = qCode;
      @(posedge clk);
      iCode <= (c == 0) ? 14'h0000 : (c == 1) ? 14'h3fff : 14'($urandom);
      qCode <= (c == 0) ? 14'h3fff : 14'($urandom);
      #1;
      check("i major", 32'(iMaj), therm(pi[13:9], 31));
      check("i mid", 32'(iMid), therm({1'b0, pi[8:5]}, 15));
      check("i lsb", 32'(iLsb), 32'(pi[4:0]));
      check("q major", 32'(qMaj), therm(pq[13:9], 31));
      check("q mid", 32'(qMid), therm({1'b0, pq[8:5]}, 15));
      check("q lsb", 32'(qLsb), 32'(pq[4:0]));
    end
  endtask

  initial begin
    #2ms;
    miscompares++;
    conclude();
  end

  initial begin
    iCode = 14'h0000;
    qCode = 14'h0000;
    resMode = 1'b0;
    {ioSeen, outSeen, pulses, lowCycles} = '0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    void'($urandom(97247));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("stable after reset", 32'(stable), 32'h1);
    // wrap from port_config_and_soft_reset to 0x1f while reading downwards
    xfer(1, 4, 5'h01, 0);
    check("io pin idle", 32'(ioSeen), 32'h0);
    check("out pin used", 32'(outSeen), 32'd32);
    xfer(0, 1, `DSC_ADDR_OFS_I, $urandom);
    xfer(0, 2, 5'h0d, $urandom); // unmapped byte then 0x0c
    ofs();
    host.xfer(0, 2'd0, `DSC_ADDR_OFS_I, 32'h0000005a, 4, junk);
    repeat (6) @(posedge clk);
    ofs();
    // config lands at the last bit of its byte inside a longer frame
    xfer(0, 2, 5'h01, 32'h00004000);
    xfer(1, 1, 5'h00, 0);
    xfer(0, 1, `DSC_ADDR_OFS_I, $urandom);
    xfer(1, 2, 5'h07, 0);
    ofs();
    xfer(0, 1, 5'h00, 32'h000000c0);
    outSeen = 0;
    ioSeen = 0;
    xfer(1, 2, 5'h0b, 0);
    check("out pin idle", 32'(outSeen), 32'h0);
    check("io pin used", 32'(ioSeen), 32'd16);
    xfer(0, 1, 5'h00, 32'h000000e0);
    xfer(1, 1, 5'h00, 0);
    ofs();
    xfer(0, 1, `DSC_ADDR_OFS_Q, $urandom);
    xfer(0, 1, 5'h00, 32'h000000e7);
    ofs();
    check("no early pulse", 32'(pulses), 32'h0);
    xfer(0, 1, 5'h00, 32'h000000c3);
    for (int i = 0; i < 50 && stable !== 1'b1; i++) @(posedge clk);
    check("reprogram pulses", 32'(pulses), 32'h1);
    check("settle bound", 32'(lowCycles > 0 && lowCycles <= SETTLE), 32'h1);
    check("stable again", 32'(stable), 32'h1);
    codes(300);
    @(posedge clk);
    resMode <= 1'b1;
    repeat (4) @(posedge clk);
    check("half scale on", 32'(halfScale), 32'h1);
    resMode <= 1'b0;
    repeat (4) @(posedge clk);
    check("half scale off", 32'(halfScale), 32'h0);
    conclude();
  end
endmodule

`default_nettype wire
